/* common/csm_pkg.sv */
// Constants and types shared by the converter status monitor bank
package csm_pkg;
    localparam int          CSM_NUM_CH       = 100;
    localparam int          CSM_CH_AW        = 7;
    localparam logic [15:0] CSM_ERR_FIRST    = 16'h0001;
    localparam logic [15:0] CSM_ERR_LAST     = 16'h0064;
    localparam logic [15:0] CSM_CONV_MATCH   = 16'h0065;
    localparam logic [15:0] CSM_MOD_FIRST    = 16'h0066;
    localparam logic [15:0] CSM_MOD_LAST     = 16'h00c9;
    localparam logic [15:0] CSM_LINK_STATE   = 16'h00ca;
    localparam logic [15:0] CSM_HEARTBEAT    = 16'h00cb;
    localparam logic [15:0] CSM_CTRL_ERR     = 16'h00cc;
    localparam logic [15:0] CSM_UNIT_FLAG    = 16'h00cd;
    // Module error word bit positions
    localparam int          CSM_EB_ADJ       = 0;
    localparam int          CSM_EB_BACKUP    = 1;
    localparam int          CSM_EB_ADC       = 2;
    localparam int          CSM_EB_LOGIC     = 5;
    localparam logic [15:0] CSM_ERR_MAX      = 16'h0027;
    // Controller link error bit positions
    localparam int          CSM_LB_NET       = 0;
    localparam int          CSM_LB_RW        = 1;
    localparam int          CSM_LB_TMO       = 2;
    localparam int          CSM_LB_INT       = 4;
    localparam logic [15:0] CSM_HB_MAX       = 16'h7530;
    localparam logic [15:0] CSM_HB_RESET     = 16'h0000;
    localparam int          CSM_RD_LATENCY   = 2;
    // Channel memory entry: {match, logic, adc, backup, adj}
    localparam int          CSM_ENT_W        = 5;
    localparam logic [4:0]  CSM_ENT_RESET    = 5'h00;

    typedef enum logic [1:0] {
        CSM_SRC_WORD  = 2'b00,
        CSM_SRC_ERR   = 2'b01,
        CSM_SRC_MATCH = 2'b10
    } csm_src_t;
endpackage

/* common/csm_mem_if.sv */
// Interface between the status bank and its per-channel memory
`timescale 1ns/1ns
interface csm_mem_if;
    import csm_pkg::*;
    logic                 wr_en;
    logic [CSM_CH_AW-1:0] wr_addr;
    logic [CSM_ENT_W-1:0] wr_data;
    logic [CSM_CH_AW-1:0] rd_addr;
    logic [CSM_ENT_W-1:0] rd_data;

    modport bank (output wr_en, output wr_addr, output wr_data, output rd_addr,
                  input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr,
                  output rd_data);
endinterface

/* hdl/csm_chan_mem.sv */
// Per-channel fault and backup-match memory with registered read data
`timescale 1ns/1ns
module csm_chan_mem
    import csm_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic reset_n,
    csm_mem_if.mem    mif
);
    logic [CSM_ENT_W-1:0] mem_r [0:CSM_NUM_CH-1];
    logic [CSM_ENT_W-1:0] rd_data_nxt;

    always_comb begin
        rd_data_nxt = mem_r[mif.rd_addr];
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            for (int i = 0; i < CSM_NUM_CH; i++) begin
                mem_r[i] <= CSM_ENT_RESET;
            end
            mif.rd_data <= CSM_ENT_RESET;
        end else begin
            if (mif.wr_en) begin
                mem_r[mif.wr_addr] <= mif.wr_data;
            end
            mif.rd_data <= rd_data_nxt;
        end
    end
endmodule

/* hdl/csm_status_bank.sv */
// Read-only status and monitor word bank of the communication converter
`timescale 1ns/1ns
module csm_status_bank
    import csm_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    input  wire logic                 bus_rd_en,
    input  wire logic                 bus_wr_en,
    input  wire logic [15:0]          bus_addr,
    input  wire logic [15:0]          bus_wr_data,
    output logic      [15:0]          bus_rd_data,
    output logic                      bus_rd_valid,
    input  wire logic                 ch_upd_valid,
    input  wire logic [CSM_CH_AW-1:0] ch_upd_index,
    input  wire logic                 ch_adj_fault,
    input  wire logic                 ch_backup_fault,
    input  wire logic                 ch_adc_fault,
    input  wire logic                 ch_logic_fault,
    input  wire logic                 ch_backup_match,
    input  wire logic                 conv_backup_match,
    input  wire logic                 collect_done,
    input  wire logic                 comm_period_tick,
    input  wire logic                 heartbeat_mode_select,
    input  wire logic                 net_op_fail,
    input  wire logic                 ctrl_rw_fail,
    input  wire logic                 ctrl_timeout,
    input  wire logic                 internal_comm_fail,
    input  wire logic                 unit_present
);
    csm_mem_if mif ();

    csm_chan_mem u_mem (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .mif     (mif)
    );

    // ------------------------------------------------------------
    // Channel updates and read address
    // ------------------------------------------------------------
    logic [15:0] err_idx;
    logic [15:0] mod_idx;
    logic        in_err;
    logic        in_mod;

    always_comb begin
        err_idx     = bus_addr - CSM_ERR_FIRST;
        mod_idx     = bus_addr - CSM_MOD_FIRST;
        in_err      = (bus_addr >= CSM_ERR_FIRST) && (bus_addr <= CSM_ERR_LAST);
        in_mod      = (bus_addr >= CSM_MOD_FIRST) && (bus_addr <= CSM_MOD_LAST);
        mif.wr_en   = ch_upd_valid;
        mif.wr_addr = ch_upd_index;
        mif.wr_data = {ch_backup_match, ch_logic_fault, ch_adc_fault,
                       ch_backup_fault, ch_adj_fault};
        mif.rd_addr = in_mod ? mod_idx[CSM_CH_AW-1:0] : err_idx[CSM_CH_AW-1:0];
    end

    // ------------------------------------------------------------
    // Heartbeat word
    // ------------------------------------------------------------
    logic [15:0] hb_r;
    logic [15:0] hb_nxt;

    always_comb begin
        hb_nxt = hb_r;
        if (comm_period_tick) begin
            if (heartbeat_mode_select) begin
                hb_nxt = (hb_r >= CSM_HB_MAX) ? 16'h0000 : hb_r + 16'h0001;
            end else begin
                hb_nxt = (hb_r == 16'h0000) ? 16'h0001 : 16'h0000;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            hb_r <= CSM_HB_RESET;
        end else begin
            hb_r <= hb_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read pipeline: stage one decodes, stage two formats
    // ------------------------------------------------------------
    logic        v1_r;
    logic        v1_nxt;
    csm_src_t    src1_r;
    csm_src_t    src1_nxt;
    logic [15:0] word1_r;
    logic [15:0] word1_nxt;
    logic [15:0] rd_data_nxt;
    logic [CSM_ENT_W-1:0] ent;

    // Writes never reach any storage here, so bus_wr_data goes unused and bus_wr_en only feeds an assertion
    always_comb begin
        v1_nxt    = bus_rd_en;
        src1_nxt  = CSM_SRC_WORD;
        word1_nxt = 16'h0000;
        if (in_err) begin
            src1_nxt = CSM_SRC_ERR;
        end else if (in_mod) begin
            src1_nxt = CSM_SRC_MATCH;
        end else begin
            case (bus_addr)
                CSM_CONV_MATCH: word1_nxt = {15'h0000, conv_backup_match};
                CSM_LINK_STATE: word1_nxt = {15'h0000, collect_done};
                CSM_HEARTBEAT:  word1_nxt = hb_r;
                CSM_CTRL_ERR:   word1_nxt = {11'h000, internal_comm_fail, 1'b0,
                                             ctrl_timeout, ctrl_rw_fail,
                                             net_op_fail};
                CSM_UNIT_FLAG:  word1_nxt = {15'h0000, unit_present};
                default:        word1_nxt = 16'h0000;
            endcase
        end
    end

    always_comb begin
        ent = mif.rd_data;
        case (src1_r)
            CSM_SRC_ERR:   rd_data_nxt = {10'h000, ent[3], 2'b00,
                                          ent[2], ent[1], ent[0]};
            CSM_SRC_MATCH: rd_data_nxt = {15'h0000, ent[4]};
            default:       rd_data_nxt = word1_r;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            v1_r         <= 1'b0;
            src1_r       <= CSM_SRC_WORD;
            word1_r      <= 16'h0000;
            bus_rd_valid <= 1'b0;
            bus_rd_data  <= 16'h0000;
        end else begin
            v1_r         <= v1_nxt;
            src1_r       <= src1_nxt;
            word1_r      <= word1_nxt;
            bus_rd_valid <= v1_r;
            bus_rd_data  <= v1_r ? rd_data_nxt : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    csm_src_t src2_r;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            src2_r <= CSM_SRC_WORD;
        end else begin
            src2_r <= src1_r;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_read_at(logic [15:0] a);
        bus_rd_en && (bus_addr == a) ##2 bus_rd_valid;
    endsequence

    sequence s_upd_then_read;
        ch_upd_valid ##1
            (bus_rd_en && in_err && (err_idx[CSM_CH_AW-1:0] == $past(ch_upd_index))
             && !(ch_upd_valid && ch_upd_index == $past(ch_upd_index)));
    endsequence

    a_err_bits_map: assert property (s_upd_then_read |-> ##2 bus_rd_data ==
        {10'h000, $past(ch_logic_fault, 3), 2'b00, $past(ch_adc_fault, 3),
         $past(ch_backup_fault, 3), $past(ch_adj_fault, 3)})
        else $error("module error word does not reflect the channel faults");

    a_err_unused_zero: assert property (bus_rd_valid && src2_r == CSM_SRC_ERR
        |-> bus_rd_data[15:6] == 10'h000 && bus_rd_data[4:3] == 2'b00)
        else $error("unused module error bits are not zero");

    a_err_sum_range: assert property (bus_rd_valid && src2_r == CSM_SRC_ERR
        |-> bus_rd_data <= CSM_ERR_MAX)
        else $error("module error word exceeds 39");

    a_conv_backup_read: assert property (s_read_at(CSM_CONV_MATCH)
        |-> bus_rd_data == {15'h0000, $past(conv_backup_match, 2)})
        else $error("converter backup monitor mismatch");

    a_mod_match_width: assert property (bus_rd_valid && src2_r == CSM_SRC_MATCH
        |-> bus_rd_data[15:1] == 15'h0000)
        else $error("module backup monitor has stray bits");

    a_link_state_read: assert property (s_read_at(CSM_LINK_STATE)
        |-> bus_rd_data == {15'h0000, $past(collect_done, 2)})
        else $error("link state word wrong");

    a_hb_toggle_step: assert property (comm_period_tick && !heartbeat_mode_select
        |=> hb_r == (($past(hb_r) == 16'h0000) ? 16'h0001 : 16'h0000))
        else $error("heartbeat did not toggle");

    a_hb_count_step: assert property (comm_period_tick && heartbeat_mode_select
        && hb_r < CSM_HB_MAX |=> hb_r == $past(hb_r) + 16'h0001)
        else $error("heartbeat did not count up");

    a_hb_count_wrap: assert property (comm_period_tick && heartbeat_mode_select
        && hb_r == CSM_HB_MAX |=> hb_r == 16'h0000)
        else $error("heartbeat did not wrap at 30000");

    a_hb_hold_idle: assert property (!comm_period_tick |=> $stable(hb_r))
        else $error("heartbeat moved without a period tick");

    a_ctrl_err_read: assert property (s_read_at(CSM_CTRL_ERR)
        |-> bus_rd_data == {11'h000, $past(internal_comm_fail, 2), 1'b0,
            $past(ctrl_timeout, 2), $past(ctrl_rw_fail, 2), $past(net_op_fail, 2)})
        else $error("controller link error word wrong");

    a_ctrl_err_unused: assert property (s_read_at(CSM_CTRL_ERR)
        |-> bus_rd_data[15:5] == 11'h000 && !bus_rd_data[3])
        else $error("controller link error unused bits set");

    a_unit_flag_read: assert property (s_read_at(CSM_UNIT_FLAG)
        |-> bus_rd_data == {15'h0000, $past(unit_present, 2)})
        else $error("unit recognition word wrong");

    a_write_no_answer: assert property (bus_wr_en && !bus_rd_en
        |-> ##2 !bus_rd_valid && bus_rd_data == 16'h0000)
        else $error("write produced a read answer");
endmodule

/* bench/csm_host_model.sv */
// Host model that issues word reads and writes to the status bank
`timescale 1ns/1ns
module csm_host_model (
    input  wire logic        sys_clk,
    output logic             bus_rd_en,
    output logic             bus_wr_en,
    output logic [15:0]      bus_addr,
    output logic [15:0]      bus_wr_data
);
    initial begin
        bus_rd_en   = 1'b0;
        bus_wr_en   = 1'b0;
        bus_addr    = 16'h0000;
        bus_wr_data = 16'h0000;
    end
    // Entered just after an edge; request is taken at the next edge
    task automatic rd(input logic [15:0] a);
        bus_wr_en = 1'b0;
        bus_rd_en = 1'b1;
        bus_addr  = a;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        bus_rd_en   = 1'b0;
        bus_wr_en   = 1'b1;
        bus_addr    = a;
        bus_wr_data = d;
        @(posedge sys_clk);
        #1;
    endtask
    // Released lines show a changed value, not the last one
    task automatic idle();
        bus_rd_en   = 1'b0;
        bus_wr_en   = 1'b0;
        bus_addr    = ~bus_addr;
        bus_wr_data = ~bus_wr_data;
        @(posedge sys_clk);
        #1;
    endtask
endmodule

/* bench/csm_status_bank_bench.sv */
// Self-checking testbench of the converter status monitor bank
`timescale 1ns/1ns
module csm_status_bank_bench;
    import csm_pkg::*;
    logic sys_clk = 1'b0, reset_n = 1'b0, rd_en, wr_en, rd_valid, upd_valid = 1'b0;
    logic [15:0] addr, wr_data, rd_data;
    logic [6:0] upd_idx = 7'h00;
    logic [4:0] f = 5'h00;
    logic cmatch = 1'b0, cdone = 1'b0, tick = 1'b0, hb_mode = 1'b0, unit = 1'b0;
    logic [3:0] lerr = 4'h0;
    logic [15:0] exp_q[$];
    logic [15:0] e;
    int error_cnt = 0, n_tests = 0, seed = 22, s;
    always #2 sys_clk = ~sys_clk;
    csm_host_model u_host (.sys_clk(sys_clk), .bus_rd_en(rd_en), .bus_wr_en(wr_en),
                           .bus_addr(addr), .bus_wr_data(wr_data));
    csm_status_bank dut (.sys_clk(sys_clk), .reset_n(reset_n), .bus_rd_en(rd_en),
        .bus_wr_en(wr_en), .bus_addr(addr), .bus_wr_data(wr_data), .bus_rd_data(rd_data),
        .bus_rd_valid(rd_valid), .ch_upd_valid(upd_valid), .ch_upd_index(upd_idx),
        .ch_adj_fault(f[0]), .ch_backup_fault(f[1]), .ch_adc_fault(f[2]),
        .ch_logic_fault(f[3]), .ch_backup_match(f[4]), .conv_backup_match(cmatch),
        .collect_done(cdone), .comm_period_tick(tick), .heartbeat_mode_select(hb_mode),
        .net_op_fail(lerr[0]), .ctrl_rw_fail(lerr[1]), .ctrl_timeout(lerr[2]),
        .internal_comm_fail(lerr[3]), .unit_present(unit));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] a, input logic [15:0] x);
        exp_q.push_back(x);
        u_host.rd(a);
    endtask
    task automatic ticks(input logic m, input int n);
        hb_mode = m;
        tick    = 1'b1;
        repeat (n) @(posedge sys_clk);
        #1;
        tick = 1'b0;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // Monitor
    // ----------------------------------------
    always @(negedge sys_clk) begin
        if (rd_valid === 1'b1) begin
            n_tests++;
            if (exp_q.size() == 0) begin
                error_cnt++;
                $display("unexpected answer: expected none, seen %h", rd_data);
            end else begin
                e = exp_q.pop_front();
                if (rd_data !== e) begin
                    error_cnt++;
                    $display("unexpected rd_data: expected %h, seen %h", e, rd_data);
                end
            end
        end
    end
    initial begin
        #200000;
        error_cnt++;
        print_verdict();
    end
    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        chk(CSM_HEARTBEAT, 16'h0000);
        chk(CSM_MOD_FIRST, 16'h0000);
        chk(16'h0000, 16'h0000);
        chk(16'h00ce, 16'h0000);
        for (int k = 0; k < 12; k++) begin
            s = $random(seed);
            {unit, cdone, cmatch, lerr} = s[6:0];
            chk(CSM_CONV_MATCH, {15'h0, cmatch});
            chk(CSM_LINK_STATE, {15'h0, cdone});
            chk(CSM_CTRL_ERR, {11'h0, lerr[3], 1'b0, lerr[2:0]});
            chk(CSM_UNIT_FLAG, {15'h0, unit});
        end
        for (int k = 0; k < 16; k++) begin
            s = $random(seed);
            upd_idx = (k == 0) ? 7'd0 : (k == 15) ? 7'd99 : 7'($unsigned(s) % 100);
            f = {s[20], 4'(k)};
            upd_valid = 1'b1;
            // Read strobe must drop during the update edge, or a stray read is taken
            u_host.idle();
            upd_valid = 1'b0;
            chk(16'h0001 + 16'(upd_idx), {10'h0, f[3], 2'b0, f[2:0]});
            chk(CSM_MOD_FIRST + 16'(upd_idx), {15'h0, f[4]});
        end
        u_host.wr(16'h0064, 16'hffff);
        u_host.wr(CSM_CTRL_ERR, 16'hffff);
        chk(16'h0064, 16'h0027);
        chk(CSM_CTRL_ERR, {11'h0, lerr[3], 1'b0, lerr[2:0]});
        u_host.idle();
        ticks(1'b0, 1);
        chk(CSM_HEARTBEAT, 16'h0001);
        u_host.idle();
        ticks(1'b0, 1);
        chk(CSM_HEARTBEAT, 16'h0000);
        u_host.idle();
        ticks(1'b1, 30000);
        chk(CSM_HEARTBEAT, CSM_HB_MAX);
        u_host.idle();
        ticks(1'b1, 4);
        chk(CSM_HEARTBEAT, 16'h0003);
        u_host.idle();
        ticks(1'b0, 1);
        chk(CSM_HEARTBEAT, 16'h0000);
        u_host.idle();
        repeat (4) @(posedge sys_clk);
        if (exp_q.size() != 0) begin
            error_cnt++;
            $display("unexpected pending answers: expected 0, seen %0d", exp_q.size());
        end
        print_verdict();
    end
endmodule
